// File: hw/ueg_endpoint_global_control.v
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ueg_defines.vh"

module ueg_endpoint_global_control #(
	parameter FRAME_CYCLES = `UEG_FRAME_CYCLES,
	parameter TIMER_W = 16
) (
	input wire clk_in, // core clock, 25 MHz
	input wire rstn_in, // async reset, active low
	input wire ce_in, // clock enable, freezes all state when low
	// register port
	input wire [15:0] reg_addr_in, // register byte address
	input wire [7:0] reg_wdata_in, // write data
	input wire reg_wr_in, // write strobe
	input wire reg_rd_in, // read strobe
	output reg [7:0] reg_rdata_out, // read data, cycle after strobe
	// frame events from the serial engine
	input wire sof_valid_in, // good start-of-frame token pulse
	input wire [10:0] frame_number_bits_in, // frame number with sof_valid_in
	input wire sof_bad_in, // corrupt start-of-frame pulse
	// enumeration events
	input wire set_address_in, // host address assignment pulse
	input wire [6:0] host_assigned_addr_bits_in, // address with set_address_in
	input wire soft_reenumerate_in, // soft re-enumeration pulse
	// token under decision
	input wire token_valid_in, // token present
	input wire [6:0] token_addr_in, // token device address
	input wire [3:0] token_ep_in, // token endpoint 0..15
	input wire token_dir_in, // token direction, one is IN
	input wire iso_fifo_empty_in, // addressed iso IN FIFO empty
	input wire xfer_done_in, // transaction on token endpoint done pulse
	// decisions
	output wire token_for_me_out, // token matches assigned address
	output wire token_answer_out, // device answers the token
	output wire token_silent_out, // device gives no response
	output wire iso_zero_len_out, // answer with zero-length data packet
	output wire token_toggle_out, // expected toggle of bulk endpoint
	output wire [2:0] pair_bulk_in_out, // IN pairs enabled
	output wire [2:0] pair_bulk_out_out, // OUT pairs enabled
	output wire [2:0] pair_in_half_out, // IN pair half on USB side
	output wire [2:0] pair_out_half_out, // OUT pair half on USB side
	output wire [6:0] function_address_out // assigned address
);

// ======================================================
// state
reg [7:0] toggle_in_q;
reg [7:0] toggle_out_q;
reg tog_dir_q;
reg tog_spare_q;
reg [2:0] tog_ep_q;
reg [10:0] frame_number_bits_q;
reg frame_running_q;
reg [TIMER_W-1:0] frame_timer_q;
reg [6:0] host_assigned_addr_bits_q;
reg iso_zero_len_reply_q;
reg [2:0] pair_bulk_out_q;
reg [2:0] pair_bulk_in_q;
reg [7:0] live_bulk_in_q;
reg [7:0] live_bulk_out_q;
reg [7:0] live_iso_in_q;
reg [7:0] live_iso_out_q;
reg [2:0] in_half_q;
reg [2:0] out_half_q;
reg [7:0] reg_rdata_d;

// ======================================================
// decoding helpers
function [2:0] ueg_bulk_index;
	input [2:0] ep;
	input paired;
	begin
		// odd endpoint of an enabled pair is folded onto its even partner
		if (paired)
			ueg_bulk_index = {ep[2:1], 1'b0}; // see R17
		else
			ueg_bulk_index = ep;
	end
endfunction

function ueg_pair_of;
	input [2:0] ep;
	input [2:0] pairs;
	begin
		case (ep[2:1])
			2'b01: ueg_pair_of = pairs[0];
			2'b10: ueg_pair_of = pairs[1];
			2'b11: ueg_pair_of = pairs[2];
			default: ueg_pair_of = 1'b0;
		endcase
	end
endfunction

function ueg_bit_at;
	input [7:0] vec;
	input [2:0] idx;
	begin
		ueg_bit_at = vec[idx];
	end
endfunction

// ======================================================
// register write decode
wire wr_toggle = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_TOGGLE_CONTROL);
wire wr_pairing = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_ENDPOINT_PAIRING);
wire wr_bulk_in = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_BULK_IN_VALID);
wire wr_bulk_out = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_BULK_OUT_VALID);
wire wr_iso_in = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_ISO_IN_VALID);
wire wr_iso_out = ce_in && reg_wr_in &&
	(reg_addr_in == `UEG_ADDR_ISO_OUT_VALID);

// force acts on the selection carried by the same write
wire [2:0] wr_ep = reg_wdata_in[`UEG_TOG_EP_MSB:0]; // see R05
wire wr_dir = reg_wdata_in[`UEG_TOG_DIR_BIT]; // see R04
wire force_one = wr_toggle && reg_wdata_in[`UEG_TOG_SET_ONE_BIT];
wire force_zero = wr_toggle && reg_wdata_in[`UEG_TOG_SET_ZERO_BIT];

// ======================================================
// token decisions
wire token_iso = token_ep_in[3];
wire [2:0] token_pairs = token_dir_in ? pair_bulk_in_q : pair_bulk_out_q;
wire token_paired = !token_iso && ueg_pair_of(token_ep_in[2:0], token_pairs);
wire [2:0] token_bulk_idx = ueg_bulk_index(token_ep_in[2:0], token_paired);
reg token_live;

always @*
begin
	token_live = 1'b0;
	case ({token_iso, token_dir_in})
		2'b00: token_live = ueg_bit_at(live_bulk_out_q, token_bulk_idx);
		2'b01: token_live = ueg_bit_at(live_bulk_in_q, token_bulk_idx);
		2'b10: token_live = ueg_bit_at(live_iso_out_q, token_ep_in[2:0]);
		2'b11: token_live = ueg_bit_at(live_iso_in_q, token_ep_in[2:0]);
		default: token_live = 1'b0;
	endcase
end

// other addresses are ignored without the processor
assign token_for_me_out = token_valid_in &&
	(token_addr_in == host_assigned_addr_bits_q); // see R12
wire iso_empty_in_tok = token_iso && token_dir_in && iso_fifo_empty_in;
assign iso_zero_len_out = token_for_me_out && token_live &&
	iso_empty_in_tok && iso_zero_len_reply_q; // see R14
// dead endpoints and empty iso FIFOs without zero-length reply stay quiet
assign token_silent_out = token_for_me_out && (!token_live ||
	(iso_empty_in_tok && !iso_zero_len_reply_q)); // see R18
assign token_answer_out = token_for_me_out && !token_silent_out;
assign token_toggle_out = token_dir_in ?
	ueg_bit_at(toggle_in_q, token_bulk_idx) :
	ueg_bit_at(toggle_out_q, token_bulk_idx);

wire xfer_bulk = ce_in && xfer_done_in && token_answer_out && !token_iso;

// ======================================================
// data toggles, processor force beats the serial engine flip
genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1)
	begin : g_tog
		wire sel_in = wr_dir && (wr_ep == gi);
		wire sel_out = !wr_dir && (wr_ep == gi);
		wire flip_in = xfer_bulk && token_dir_in && (token_bulk_idx == gi);
		wire flip_out = xfer_bulk && !token_dir_in &&
			(token_bulk_idx == gi);
		always @(posedge clk_in or negedge rstn_in)
		begin
			if (!rstn_in)
			begin
				toggle_in_q[gi] <= 1'b0;
				toggle_out_q[gi] <= 1'b0;
			end
			else if (ce_in)
			begin
				if (sel_in && force_zero)
					toggle_in_q[gi] <= 1'b0; // see R02
				else if (sel_in && force_one)
					toggle_in_q[gi] <= 1'b1; // see R01
				else if (flip_in)
					toggle_in_q[gi] <= !toggle_in_q[gi];
				if (sel_out && force_zero)
					toggle_out_q[gi] <= 1'b0; // see R02
				else if (sel_out && force_one)
					toggle_out_q[gi] <= 1'b1; // see R01
				else if (flip_out)
					toggle_out_q[gi] <= !toggle_out_q[gi];
			end
		end
	end
endgenerate

always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		tog_dir_q <= 1'b0;
		tog_spare_q <= 1'b0;
		tog_ep_q <= 3'h0;
	end
	else if (wr_toggle)
	begin
		tog_dir_q <= wr_dir; // see R04
		tog_spare_q <= reg_wdata_in[`UEG_TOG_SPARE_BIT];
		tog_ep_q <= wr_ep; // see R05
	end
end

// ======================================================
// frame count
wire frame_timeout = frame_running_q &&
	(frame_timer_q == FRAME_CYCLES[TIMER_W-1:0] - 1'b1);
// a frame only runs after the first good start-of-frame
wire frame_synth = ce_in && !sof_valid_in && frame_running_q &&
	(sof_bad_in || frame_timeout); // see R09

always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		frame_number_bits_q <= 11'h000;
		frame_running_q <= 1'b0;
		frame_timer_q <= {TIMER_W{1'b0}};
	end
	else if (ce_in)
	begin
		if (sof_valid_in)
		begin
			frame_number_bits_q <= frame_number_bits_in; // see R08
			frame_running_q <= 1'b1;
			frame_timer_q <= {TIMER_W{1'b0}};
		end
		else if (frame_synth)
		begin
			if (frame_number_bits_q == `UEG_FRAME_MAX)
				frame_number_bits_q <= 11'h000; // see R10
			else
				frame_number_bits_q <= frame_number_bits_q + 11'h001;
			frame_timer_q <= {TIMER_W{1'b0}};
		end
		else if (frame_running_q)
			frame_timer_q <= frame_timer_q + 1'b1;
		if (soft_reenumerate_in)
			frame_running_q <= 1'b0;
	end
end

// ======================================================
// function address, a new assignment wins over a clear
always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
		host_assigned_addr_bits_q <= 7'h00;
	else if (ce_in)
	begin
		if (set_address_in)
			host_assigned_addr_bits_q <= host_assigned_addr_bits_in; // see R11
		else if (soft_reenumerate_in)
			host_assigned_addr_bits_q <= 7'h00; // see R13
	end
end

assign function_address_out = host_assigned_addr_bits_q;

// ======================================================
// pairing and live bits
always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		iso_zero_len_reply_q <= `UEG_RST_ZERO_LEN;
		pair_bulk_out_q <= 3'h0;
		pair_bulk_in_q <= 3'h0;
		live_bulk_in_q <= `UEG_RST_BULK_IN_VALID; // see R20
		live_bulk_out_q <= `UEG_RST_BULK_OUT_VALID; // see R20
		live_iso_in_q <= `UEG_RST_ISO_IN_VALID; // see R20
		live_iso_out_q <= `UEG_RST_ISO_OUT_VALID; // see R20
	end
	else
	begin
		if (wr_pairing)
		begin
			iso_zero_len_reply_q <= reg_wdata_in[`UEG_PAIR_ZERO_LEN_BIT];
			pair_bulk_out_q <=
				reg_wdata_in[`UEG_PAIR_OUT_LSB+2:`UEG_PAIR_OUT_LSB]; // see R15
			pair_bulk_in_q <=
				reg_wdata_in[`UEG_PAIR_IN_LSB+2:`UEG_PAIR_IN_LSB]; // see R16
		end
		if (wr_bulk_in)
			live_bulk_in_q <= reg_wdata_in; // see R19
		if (wr_bulk_out)
			live_bulk_out_q <= reg_wdata_in; // see R19
		if (wr_iso_in)
			live_iso_in_q <= reg_wdata_in; // see R19
		if (wr_iso_out)
			live_iso_out_q <= reg_wdata_in; // see R19
	end
end

assign pair_bulk_in_out = pair_bulk_in_q;
assign pair_bulk_out_out = pair_bulk_out_q;

// ======================================================
// ping-pong halves: USB side swaps after each finished transfer,
// the processor always works the other half
generate
	for (gi = 0; gi < 3; gi = gi + 1)
	begin : g_pair
		wire hit = xfer_bulk && token_paired &&
			(token_ep_in[2:1] == gi + 1);
		always @(posedge clk_in or negedge rstn_in)
		begin
			if (!rstn_in)
			begin
				in_half_q[gi] <= 1'b0;
				out_half_q[gi] <= 1'b0;
			end
			else if (ce_in)
			begin
				if (!pair_bulk_in_q[gi])
					in_half_q[gi] <= 1'b0;
				else if (hit && token_dir_in)
					in_half_q[gi] <= !in_half_q[gi]; // see R16
				if (!pair_bulk_out_q[gi])
					out_half_q[gi] <= 1'b0;
				else if (hit && !token_dir_in)
					out_half_q[gi] <= !out_half_q[gi]; // see R15
			end
		end
	end
endgenerate

assign pair_in_half_out = in_half_q;
assign pair_out_half_out = out_half_q;

// ======================================================
// read path, unmapped addresses read zero
wire sel_toggle = tog_dir_q ? ueg_bit_at(toggle_in_q, tog_ep_q) :
	ueg_bit_at(toggle_out_q, tog_ep_q);

always @*
begin
	reg_rdata_d = 8'h00;
	case (reg_addr_in)
		`UEG_ADDR_TOGGLE_CONTROL: reg_rdata_d = {sel_toggle, 2'b00,
			tog_dir_q, tog_spare_q, tog_ep_q}; // see R06
		`UEG_ADDR_FRAME_COUNT_LOW: reg_rdata_d = frame_number_bits_q[7:0];
		`UEG_ADDR_FRAME_COUNT_HIGH:
			reg_rdata_d = {5'h00, frame_number_bits_q[10:8]}; // see R08
		`UEG_ADDR_FUNCTION_ADDRESS:
			reg_rdata_d = {1'b0, host_assigned_addr_bits_q};
		`UEG_ADDR_ENDPOINT_PAIRING: reg_rdata_d = {iso_zero_len_reply_q,
			1'b0, pair_bulk_out_q, pair_bulk_in_q};
		`UEG_ADDR_BULK_IN_VALID: reg_rdata_d = live_bulk_in_q;
		`UEG_ADDR_BULK_OUT_VALID: reg_rdata_d = live_bulk_out_q;
		`UEG_ADDR_ISO_IN_VALID: reg_rdata_d = live_iso_in_q;
		`UEG_ADDR_ISO_OUT_VALID: reg_rdata_d = live_iso_out_q;
		default: reg_rdata_d = 8'h00;
	endcase
end

// data stand one cycle only, zero otherwise
always @(posedge clk_in or negedge rstn_in)
begin
	if (!rstn_in)
		reg_rdata_out <= 8'h00;
	else if (ce_in)
		reg_rdata_out <= reg_rd_in ? reg_rdata_d : 8'h00;
end

endmodule // ueg_endpoint_global_control
`default_nettype wire

// File: hw/ueg_defines.vh
// Notes on behaviour
// R01 - writing one to the DATA1 force bit sets the selected endpoint toggle.
// R02 - writing one to the DATA0 force bit clears the selected endpoint toggle.
// R03 - software writes direction and number first, unchanged during force writes; the code takes both from the force write itself.
// R04 - direction select zero means OUT endpoint, one means IN endpoint.
// R05 - three-bit endpoint number in low bits selects endpoint 0 to 7.
// R06 - read-only top bit shows selected endpoint toggle, one for DATA1.
// R07 - host sends start-of-frame each millisecond with an 11-bit frame number.
// R08 - each start-of-frame loads frame number into low and high count registers.
// R09 - missing or corrupt start-of-frame makes an internal frame and counts one.
// R10 - the internally counted frame number wraps from 2047 to zero.
// R11 - host-assigned 7-bit address is captured into read-only address register.
// R12 - only tokens to the current assigned address are answered.
// R13 - soft re-enumeration clears the address so default address zero answers.
// R14 - iso IN token on empty FIFO: silent, or zero-length packet when enabled.
// R15 - bulk OUT pair bits enable double buffering for OUT pairs 2/3, 4/5, 6/7.
// R16 - bulk IN pair bits enable double buffering for IN pairs 2/3, 4/5, 6/7.
// R17 - with a pair enabled, software uses only the even endpoint of it.
// R18 - endpoint with live bit zero gets no response at all, not a NAK.
// R19 - four 8-bit live registers: bulk IN, bulk OUT, iso IN, iso OUT.
// R20 - live bits reset to the endpoints of the default device personality.
`ifndef UEG_DEFINES_VH
`define UEG_DEFINES_VH

// ======================================================
// register byte addresses
`define UEG_ADDR_TOGGLE_CONTROL 16'h7fd7
`define UEG_ADDR_FRAME_COUNT_LOW 16'h7fd8
`define UEG_ADDR_FRAME_COUNT_HIGH 16'h7fd9
`define UEG_ADDR_FUNCTION_ADDRESS 16'h7fdb
`define UEG_ADDR_ENDPOINT_PAIRING 16'h7fdd
`define UEG_ADDR_BULK_IN_VALID 16'h7fde
`define UEG_ADDR_BULK_OUT_VALID 16'h7fdf
`define UEG_ADDR_ISO_IN_VALID 16'h7fe0
`define UEG_ADDR_ISO_OUT_VALID 16'h7fe1

// ======================================================
// toggle control fields
`define UEG_TOG_VALUE_BIT 7
`define UEG_TOG_SET_ONE_BIT 6
`define UEG_TOG_SET_ZERO_BIT 5
`define UEG_TOG_DIR_BIT 4
`define UEG_TOG_SPARE_BIT 3
`define UEG_TOG_EP_MSB 2

// ======================================================
// pairing fields
`define UEG_PAIR_ZERO_LEN_BIT 7
`define UEG_PAIR_OUT_LSB 3
`define UEG_PAIR_IN_LSB 0

// ======================================================
// reset values
`define UEG_RST_BULK_IN_VALID 8'h57
`define UEG_RST_BULK_OUT_VALID 8'h55
`define UEG_RST_ISO_IN_VALID 8'h07
`define UEG_RST_ISO_OUT_VALID 8'h07
`define UEG_RST_PAIRING 8'h00
`define UEG_RST_ZERO_LEN 1'b0

// ======================================================
// timing
`define UEG_CLK_PERIOD_NS 40
`define UEG_FRAME_PERIOD_NS 1000000
`define UEG_FRAME_CYCLES (`UEG_FRAME_PERIOD_NS / `UEG_CLK_PERIOD_NS)
`define UEG_FRAME_MAX 11'h7ff

`endif

// File: testbench/ueg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ueg_host_model (
	input wire logic clk_in, // core clock
	output logic sof_valid_out, // good frame start
	output logic [10:0] fnum_out, // frame number
	output logic sof_bad_out, // garbled frame start
	output logic set_addr_out, // address assign
	output logic [6:0] new_addr_out, // assigned address
	output logic reenum_out, // soft re-enumeration
	output logic tok_v_out, // token present
	output logic [6:0] tok_a_out, // token address
	output logic [3:0] tok_ep_out, // token endpoint
	output logic tok_dir_out, // token direction, one is IN
	output logic empty_out, // iso FIFO empty
	output logic done_out // transaction done
);
	// ======================================================
	// idle state
	initial
	begin
		{sof_valid_out, sof_bad_out, set_addr_out, reenum_out} = 4'h0;
		{tok_v_out, tok_dir_out, empty_out, done_out} = 4'h0;
		fnum_out = 11'h000;
		new_addr_out = 7'h00;
		tok_a_out = 7'h00;
		tok_ep_out = 4'h0;
	end
	// ======================================================
	// frames and enumeration
	task automatic sof(input logic [10:0] n, input logic bad);
		@(posedge clk_in);
		sof_valid_out <= !bad;
		sof_bad_out <= bad;
		fnum_out <= n;
		@(posedge clk_in);
		sof_valid_out <= 1'b0;
		sof_bad_out <= 1'b0;
		// released lines must not keep the last value
		fnum_out <= ~n;
	endtask
	task automatic set_addr(input logic [6:0] a);
		@(posedge clk_in);
		set_addr_out <= 1'b1;
		new_addr_out <= a;
		@(posedge clk_in);
		set_addr_out <= 1'b0;
		new_addr_out <= ~a;
	endtask
	task automatic reenum;
		@(posedge clk_in);
		reenum_out <= 1'b1;
		@(posedge clk_in);
		reenum_out <= 1'b0;
	endtask
	// ======================================================
	// tokens, held until the next call
	task automatic token(input logic [6:0] a, input logic [3:0] e,
		input logic d, input logic emp);
		@(posedge clk_in);
		tok_v_out <= 1'b1;
		tok_a_out <= a;
		tok_ep_out <= e;
		tok_dir_out <= d;
		empty_out <= emp;
		#1;
	endtask
	task automatic done;
		@(posedge clk_in);
		done_out <= 1'b1;
		@(posedge clk_in);
		done_out <= 1'b0;
		#1;
	endtask
endmodule // ueg_host_model
`default_nettype wire

// File: testbench/ueg_egc_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ueg_defines.vh"
module ueg_egc_sva (
	input wire clk_in, // core clock
	input wire rstn_in, // async reset, active low
	input wire ce_in, // clock enable
	input wire [15:0] reg_addr_in, // register address
	input wire reg_rd_in, // read strobe
	input wire [7:0] reg_rdata_out, // read data
	input wire set_address_in, // address assign
	input wire [6:0] host_assigned_addr_bits_in, // new address
	input wire soft_reenumerate_in, // re-enumeration
	input wire token_valid_in, // token present
	input wire [6:0] token_addr_in, // token address
	input wire [3:0] token_ep_in, // token endpoint
	input wire token_dir_in, // token direction
	input wire iso_fifo_empty_in, // iso FIFO empty
	input wire token_for_me_out, // address match
	input wire token_answer_out, // answered
	input wire token_silent_out, // no response
	input wire iso_zero_len_out, // zero-length reply
	input wire [6:0] function_address_out // assigned address
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	a_rdata_idle: assert property (ce_in && !reg_rd_in |=>
		reg_rdata_out == 8'h00) else $error("read data not idle");
	a_frame_high: assert property (ce_in && reg_rd_in &&
		reg_addr_in == `UEG_ADDR_FRAME_COUNT_HIGH |=>
		reg_rdata_out[7:3] == 5'h00) else $error("frame high top bits");
	a_addr_read: assert property (ce_in && reg_rd_in &&
		reg_addr_in == `UEG_ADDR_FUNCTION_ADDRESS |=>
		reg_rdata_out == {1'b0, $past(function_address_out)})
		else $error("address read wrong");
	a_addr_load: assert property (ce_in && set_address_in |=>
		function_address_out == $past(host_assigned_addr_bits_in))
		else $error("address not loaded");
	a_addr_clear: assert property (ce_in && soft_reenumerate_in &&
		!set_address_in |=> function_address_out == 7'h00)
		else $error("address not cleared");
	a_addr_hold: assert property (!set_address_in &&
		!soft_reenumerate_in |=> $stable(function_address_out))
		else $error("address changed alone");
	a_match_addr: assert property (token_for_me_out ==
		(token_valid_in && token_addr_in == function_address_out))
		else $error("address match wrong");
	a_answer_split: assert property (token_answer_out ==
		(token_for_me_out && !token_silent_out))
		else $error("answer and silence disagree");
	a_other_quiet: assert property (!token_for_me_out |->
		!token_silent_out && !iso_zero_len_out)
		else $error("foreign token handled");
	a_zero_len: assert property (iso_zero_len_out |->
		token_answer_out && token_dir_in && token_ep_in[3] &&
		iso_fifo_empty_in) else $error("zero-length reply wrong");
endmodule // ueg_egc_sva
`default_nettype wire

// File: testbench/ueg_endpoint_global_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ueg_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module ueg_endpoint_global_control_bench;
	localparam FC = 20;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic ce_in = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00;
	logic [15:0] k;
	logic [31:0] rv = {`UEG_RST_ISO_OUT_VALID, `UEG_RST_ISO_IN_VALID,
		`UEG_RST_BULK_OUT_VALID, `UEG_RST_BULK_IN_VALID};
	wire sof_v, sof_b, set_a, ren, tv, tdir, emp, xd;
	wire [10:0] fnum;
	wire [6:0] naddr, ta, faddr;
	wire [3:0] tep;
	wire [7:0] rdata;
	wire me, ans, sil, zl, tog;
	wire [2:0] pin, pout, hin, hout;
	ueg_endpoint_global_control #(.FRAME_CYCLES(FC), .TIMER_W(16)) dut_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .sof_valid_in(sof_v),
		.frame_number_bits_in(fnum), .sof_bad_in(sof_b),
		.set_address_in(set_a), .host_assigned_addr_bits_in(naddr),
		.soft_reenumerate_in(ren), .token_valid_in(tv), .token_addr_in(ta),
		.token_ep_in(tep), .token_dir_in(tdir), .iso_fifo_empty_in(emp),
		.xfer_done_in(xd), .token_for_me_out(me), .token_answer_out(ans),
		.token_silent_out(sil), .iso_zero_len_out(zl),
		.token_toggle_out(tog), .pair_bulk_in_out(pin),
		.pair_bulk_out_out(pout), .pair_in_half_out(hin),
		.pair_out_half_out(hout), .function_address_out(faddr)
	);
	ueg_host_model host_u (
		.clk_in(clk_in), .sof_valid_out(sof_v), .fnum_out(fnum),
		.sof_bad_out(sof_b), .set_addr_out(set_a), .new_addr_out(naddr),
		.reenum_out(ren), .tok_v_out(tv), .tok_a_out(ta), .tok_ep_out(tep),
		.tok_dir_out(tdir), .empty_out(emp), .done_out(xd)
	);
	initial
	begin
		forever #20 clk_in = ~clk_in;
	end
	// ======================================================
	// register port tasks and verdict
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// tests take a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			final_report();
		end
	end
	// ======================================================
	// test sequence
	initial
	begin
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (k = 0; k < 4; k++)
		begin
			rc(`UEG_ADDR_BULK_IN_VALID + k, rv[8*k +: 8]);
			wr(`UEG_ADDR_BULK_IN_VALID + k, ~rv[8*k +: 8]);
			rc(`UEG_ADDR_BULK_IN_VALID + k, ~rv[8*k +: 8]);
			wr(`UEG_ADDR_BULK_IN_VALID + k, rv[8*k +: 8]);
		end
		rc(`UEG_ADDR_ENDPOINT_PAIRING, `UEG_RST_PAIRING);
		wr(`UEG_ADDR_FUNCTION_ADDRESS, 8'h7f);
		rc(`UEG_ADDR_FUNCTION_ADDRESS, 8'h00);
		wr(`UEG_ADDR_FRAME_COUNT_LOW, 8'hff);
		rc(`UEG_ADDR_FRAME_COUNT_LOW, 8'h00);
		rc(16'h7fda, 8'h00);
		// a low clock enable must swallow the write
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(`UEG_ADDR_BULK_IN_VALID, 8'h00);
		ce_in <= 1'b1;
		rc(`UEG_ADDR_BULK_IN_VALID, rv[7:0]);
		$display("register test done");
		// direction and number travel in the same write as the force
		for (k = 0; k < 8; k++)
		begin
			wr(`UEG_ADDR_TOGGLE_CONTROL, {3'b010, 2'b10, k[2:0]});
			rc(`UEG_ADDR_TOGGLE_CONTROL, {3'b100, 2'b10, k[2:0]});
			host_u.token(7'h00, {1'b0, k[2:0]}, 1'b1, 1'b0);
			`CHK(tog, 1'b1)
			wr(`UEG_ADDR_TOGGLE_CONTROL, {3'b000, 2'b00, k[2:0]});
			rc(`UEG_ADDR_TOGGLE_CONTROL, {3'b000, 2'b00, k[2:0]});
			wr(`UEG_ADDR_TOGGLE_CONTROL, {3'b001, 2'b10, k[2:0]});
			rc(`UEG_ADDR_TOGGLE_CONTROL, {3'b000, 2'b10, k[2:0]});
		end
		$display("toggle test done");
		host_u.sof(11'h5a3, 1'b0);
		rc(`UEG_ADDR_FRAME_COUNT_LOW, 8'ha3);
		rc(`UEG_ADDR_FRAME_COUNT_HIGH, 8'h05);
		host_u.sof(11'h000, 1'b1);
		rc(`UEG_ADDR_FRAME_COUNT_LOW, 8'ha4);
		host_u.sof(11'h7ff, 1'b0);
		repeat (FC + 2) @(posedge clk_in);
		rc(`UEG_ADDR_FRAME_COUNT_LOW, 8'h00);
		rc(`UEG_ADDR_FRAME_COUNT_HIGH, 8'h00);
		$display("frame test done");
		host_u.set_addr(7'h2b);
		rc(`UEG_ADDR_FUNCTION_ADDRESS, 8'h2b);
		host_u.token(7'h2b, 4'h2, 1'b0, 1'b0);
		`CHK(ans, 1'b1)
		host_u.token(7'h2c, 4'h2, 1'b0, 1'b0);
		`CHK({me, ans}, 2'b00)
		host_u.token(7'h2b, 4'h1, 1'b0, 1'b0);
		`CHK({ans, sil}, 2'b01)
		host_u.token(7'h2b, 4'h8, 1'b1, 1'b1);
		`CHK({sil, zl}, 2'b10)
		wr(`UEG_ADDR_ENDPOINT_PAIRING, 8'h80);
		#1;
		`CHK({ans, zl}, 2'b11)
		wr(`UEG_ADDR_ENDPOINT_PAIRING, 8'h3f);
		rc(`UEG_ADDR_ENDPOINT_PAIRING, 8'h3f);
		`CHK({pin, pout}, 6'h3f)
		host_u.token(7'h2b, 4'h3, 1'b1, 1'b0);
		`CHK(ans, 1'b1)
		host_u.done();
		`CHK(hin, 3'h1)
		host_u.token(7'h2b, 4'h2, 1'b0, 1'b0);
		host_u.done();
		`CHK(hout, 3'h1)
		host_u.reenum();
		rc(`UEG_ADDR_FUNCTION_ADDRESS, 8'h00);
		host_u.token(7'h00, 4'h0, 1'b0, 1'b0);
		`CHK(me, 1'b1)
		$display("address and token test done");
		final_report();
	end
endmodule // ueg_endpoint_global_control_bench
bind ueg_endpoint_global_control ueg_egc_sva chk_u (
	.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .set_address_in(set_address_in),
	.host_assigned_addr_bits_in(host_assigned_addr_bits_in),
	.soft_reenumerate_in(soft_reenumerate_in),
	.token_valid_in(token_valid_in), .token_addr_in(token_addr_in),
	.token_ep_in(token_ep_in), .token_dir_in(token_dir_in),
	.iso_fifo_empty_in(iso_fifo_empty_in),
	.token_for_me_out(token_for_me_out),
	.token_answer_out(token_answer_out),
	.token_silent_out(token_silent_out),
	.iso_zero_len_out(iso_zero_len_out),
	.function_address_out(function_address_out)
);
`default_nettype wire
